// >>> include/dcp_pkg.sv
// constants, types and helpers shared by the downconverter path files
package dcp_pkg;
    // register offsets and reset values
    localparam logic [14:0] DCP_ADDR_CTRL = 15'h0350;
    localparam logic [14:0] DCP_ADDR_INSEL = 15'h0351;
    localparam logic [7:0] DCP_CTRL_RST = 8'h00;
    localparam logic [7:0] DCP_INSEL_RST = 8'h00;
    localparam logic [7:0] DCP_INSEL_RW_MASK = 8'hf5;
    // field positions of the control register
    localparam int DCP_MIX_BIT = 7;
    localparam int DCP_GAIN_BIT = 6;
    localparam int DCP_IFM_LSB = 4;
    localparam int DCP_C2R_BIT = 3;
    localparam int DCP_DEC_LSB = 0;
    // field positions of the input select register
    localparam int DCP_EXT_LSB = 4;
    localparam int DCP_QSEL_BIT = 2;
    localparam int DCP_ISEL_BIT = 0;
    // sample width
    localparam int DCP_SW = 16;
    // basic and extended decimation codes
    localparam logic [2:0] DCP_DEC_EXT = 3'h7;
    localparam logic [3:0] DCP_EXT_TB_HB4 = 4'h0;
    localparam logic [3:0] DCP_EXT_FB_HB1 = 4'h2;
    localparam logic [3:0] DCP_EXT_FB_HB2 = 4'h3;
    localparam logic [3:0] DCP_EXT_FB_HB3 = 4'h4;
    // stage enable bit positions
    localparam int DCP_STG_HB1 = 0;
    localparam int DCP_STG_HB2 = 1;
    localparam int DCP_STG_HB3 = 2;
    localparam int DCP_STG_HB4 = 3;
    localparam int DCP_STG_TB = 4;
    localparam int DCP_STG_FB = 5;
    // intermediate frequency modes
    typedef enum logic [1:0] {
        DCP_IF_VAR = 2'b00,
        DCP_IF_ZERO = 2'b01,
        DCP_IF_FS = 2'b10,
        DCP_IF_TEST = 2'b11
    } dcp_ifmode_t;

    // doubling with saturation, the 6 dB gain step
    function automatic logic [DCP_SW-1:0] dcp_sat_x2(input logic [DCP_SW-1:0] x);
        if (x[DCP_SW-1] != x[DCP_SW-2]) begin
            return x[DCP_SW-1] ? {1'b1, {(DCP_SW-1){1'b0}}} : {1'b0, {(DCP_SW-1){1'b1}}};
        end
        return {x[DCP_SW-2:0], 1'b0};
    endfunction

    // negation with saturation, most negative value maps to most positive
    function automatic logic [DCP_SW-1:0] dcp_sat_neg(input logic [DCP_SW-1:0] x);
        if (x == {1'b1, {(DCP_SW-1){1'b0}}}) begin
            return {1'b0, {(DCP_SW-1){1'b1}}};
        end
        return (~x) + 16'h0001;
    endfunction
endpackage

// >>> hdl/dcp_ratio_decode.sv
// decimation code to stage cascade and ratio decoder
`timescale 1ns/100ps
module dcp_ratio_decode import dcp_pkg::*; (
    input wire logic [2:0] dec_code,
    input wire logic [3:0] ext_code,
    input wire logic real_out,
    output logic [5:0] ratio,
    output logic [5:0] stages,
    output logic code_bad
);
    logic [5:0] cplx;

    // complex ratio and stage set; real output halves every ratio
    always_comb begin
        cplx = 6'h00;
        stages = 6'h00;
        code_bad = 1'b0;
        case (dec_code)
            3'b000: begin cplx = 6'd4; stages = 6'h03; end // RULE5
            3'b001: begin cplx = 6'd8; stages = 6'h07; end // RULE5
            3'b010: begin cplx = 6'd16; stages = 6'h0f; end // RULE5
            3'b011: begin cplx = 6'd2; stages = 6'h01; end // RULE6
            3'b100: begin cplx = 6'd6; stages = 6'h11; end // RULE7
            3'b101: begin cplx = 6'd12; stages = 6'h13; end // RULE7
            3'b110: begin cplx = 6'd24; stages = 6'h17; end // RULE7
            default: begin
                // extended field only consulted here
                case (ext_code) // RULE8 RULE9
                    DCP_EXT_TB_HB4: begin cplx = 6'd48; stages = 6'h1f; end // RULE10
                    DCP_EXT_FB_HB1: begin cplx = 6'd10; stages = 6'h21; end // RULE11
                    DCP_EXT_FB_HB2: begin cplx = 6'd20; stages = 6'h23; end // RULE12
                    DCP_EXT_FB_HB3: begin cplx = 6'd40; stages = 6'h27; end // RULE12
                    default: code_bad = 1'b1;
                endcase
            end
        endcase
        ratio = real_out ? {1'b0, cplx[5:1]} : cplx; // RULE4
    end
endmodule

// >>> hdl/dcp_decimator.sv
// keep one sample in every ratio samples
`timescale 1ns/100ps
module dcp_decimator import dcp_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] ratio,
    input wire logic real_out,
    input wire logic in_vld,
    input wire logic [DCP_SW-1:0] in_i,
    input wire logic [DCP_SW-1:0] in_q,
    output logic [DCP_SW-1:0] out_i,
    output logic [DCP_SW-1:0] out_q,
    output logic out_i_vld,
    output logic out_q_vld
);
    typedef struct packed {
        logic [5:0] cnt;
        logic [5:0] prev;
        logic [DCP_SW-1:0] i;
        logic [DCP_SW-1:0] q;
        logic iv;
        logic qv;
    } dcp_dec_state_t;

    dcp_dec_state_t st_reg;
    dcp_dec_state_t st_next;

    // a ratio change restarts the phase so the first kept sample is clean
    always_comb begin
        st_next = st_reg;
        st_next.iv = 1'b0;
        st_next.qv = 1'b0;
        if (ratio != st_reg.prev) begin
            st_next.prev = ratio;
            st_next.cnt = 6'h00;
        end else if (in_vld && ratio != 6'h00) begin
            if (st_reg.cnt == 6'h00) begin
                st_next.i = in_i;
                st_next.q = in_q;
                st_next.iv = 1'b1;
                st_next.qv = !real_out; // RULE4
            end
            st_next.cnt = (st_reg.cnt == ratio - 6'h01) ? 6'h00 : st_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_i = st_reg.i;
    assign out_q = st_reg.q;
    assign out_i_vld = st_reg.iv;
    assign out_q_vld = st_reg.qv;
endmodule

// >>> hdl/dcp_path_config.sv
// second downconverter path: configuration registers and datapath selection
// Operation
// RULE1 - control bit 7 low mixes one real channel into both I and Q, high takes I and Q apart.
// RULE2 - control bit 6 high doubles every sample for 6 dB of gain, low leaves unity gain; the test pattern is not doubled.
// RULE3 - control bits 5:4 pick variable IF, zero IF, sample-rate IF or a test pattern.
// RULE4 - control bit 3 high drops Q and turns I into a real stream by an extra mixing step; in test mode I carries the ramp unmixed.
// RULE5 - codes 000, 001, 010 cascade two, three or four half-bands for 4, 8, 16 (halved if real).
// RULE6 - code 011 uses only the first half-band for 2, or 1 with real output.
// RULE7 - codes 100 to 110 add the third-band after one to three half-bands for 6, 12, 24.
// RULE8 - code 111 hands the ratio choice to the extended field in bits 7:4 of input select.
// RULE9 - the extended field is ignored whenever the basic code is not 111.
// RULE10 - extended code 0 runs the third-band after all four half-bands for 48, or 24 real.
// RULE11 - extended code 2 runs the fifth-band with half-band one for 10, or 5 real.
// RULE12 - extended codes 3 and 4 add half-band two, then three, for 20 and 40, halved if real.
// RULE13 - input select bits 0 and 2 choose channel A or B for I and Q, bits 1 and 3 read zero.
// RULE14 - software avoids unlisted extended codes and keeps mixer type consistent with inputs.
`timescale 1ns/100ps
module dcp_path_config import dcp_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [14:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic smp_vld,
    input wire logic [DCP_SW-1:0] smp_a,
    input wire logic [DCP_SW-1:0] smp_b,
    output logic [DCP_SW-1:0] out_i,
    output logic [DCP_SW-1:0] out_q,
    output logic out_i_vld,
    output logic out_q_vld,
    output logic [5:0] stage_en,
    output logic [5:0] decim_ratio,
    output logic decim_code_bad,
    output logic [1:0] intermediate_freq_mode
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] insel;
        logic [7:0] rdata;
        logic rvalid;
        logic [DCP_SW-1:0] i;
        logic [DCP_SW-1:0] q;
        logic vld;
        logic [1:0] ph;
        logic [DCP_SW-1:0] ramp;
        logic [5:0] ratio;
        logic [5:0] stages;
        logic bad;
    } dcp_state_t;

    dcp_state_t st_reg;
    dcp_state_t st_next;

    // field views of the two registers
    logic mixer_type_bit;
    logic six_db_gain_bit;
    logic real_output_enable;
    logic [2:0] decim_ratio_code;
    logic [3:0] ext_ratio_code;
    logic quad_source_select;
    logic inphase_source_select;
    dcp_ifmode_t if_mode;

    assign mixer_type_bit = st_reg.ctrl[DCP_MIX_BIT];
    assign six_db_gain_bit = st_reg.ctrl[DCP_GAIN_BIT];
    assign real_output_enable = st_reg.ctrl[DCP_C2R_BIT];
    assign decim_ratio_code = st_reg.ctrl[DCP_DEC_LSB +: 3];
    assign ext_ratio_code = st_reg.insel[DCP_EXT_LSB +: 4];
    assign quad_source_select = st_reg.insel[DCP_QSEL_BIT];
    assign inphase_source_select = st_reg.insel[DCP_ISEL_BIT];
    assign if_mode = dcp_ifmode_t'(st_reg.ctrl[DCP_IFM_LSB +: 2]);

    // source choice and gain ahead of the mixing stage
    logic q_from_b;
    logic [DCP_SW-1:0] isrc;
    logic [DCP_SW-1:0] qsrc;
    logic [DCP_SW-1:0] isrc_x2;
    logic [DCP_SW-1:0] gi;
    logic [DCP_SW-1:0] gq;

    // a real mixer reuses the I channel for Q so both carry one real input
    assign q_from_b = mixer_type_bit ? quad_source_select : inphase_source_select; // RULE1
    assign isrc = inphase_source_select ? smp_b : smp_a; // RULE13
    assign qsrc = q_from_b ? smp_b : smp_a; // RULE13
    assign isrc_x2 = dcp_sat_x2(isrc);
    // doubling saturates rather than wraps so a full-scale input stays sane
    assign gi = six_db_gain_bit ? isrc_x2 : isrc; // RULE2
    assign gq = six_db_gain_bit ? dcp_sat_x2(qsrc) : qsrc; // RULE2

    // cascade and ratio from the registered codes
    logic [5:0] dec_ratio;
    logic [5:0] dec_stages;
    logic dec_bad;

    dcp_ratio_decode u_decode (
        .dec_code(decim_ratio_code),
        .ext_code(ext_ratio_code),
        .real_out(real_output_enable),
        .ratio(dec_ratio),
        .stages(dec_stages),
        .code_bad(dec_bad)
    );

    // register access, mixing and sequencing
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        st_next.vld = smp_vld;
        st_next.ratio = dec_ratio;
        st_next.stages = dec_stages;
        st_next.bad = dec_bad;
        if (cfg_wr) begin
            if (cfg_addr == DCP_ADDR_CTRL) begin
                st_next.ctrl = cfg_wdata;
            end else if (cfg_addr == DCP_ADDR_INSEL) begin
                st_next.insel = cfg_wdata & DCP_INSEL_RW_MASK; // RULE13
            end
        end
        // unmapped offsets read back as zero
        if (cfg_rd) begin
            st_next.rvalid = 1'b1;
            if (cfg_addr == DCP_ADDR_CTRL) begin
                st_next.rdata = st_reg.ctrl;
            end else if (cfg_addr == DCP_ADDR_INSEL) begin
                st_next.rdata = st_reg.insel;
            end else begin
                st_next.rdata = 8'h00;
            end
        end
        if (smp_vld) begin
            case (if_mode) // RULE3
                DCP_IF_TEST: begin
                    st_next.i = st_reg.ramp;
                    st_next.q = ~st_reg.ramp;
                    st_next.ramp = st_reg.ramp + 16'h0001;
                end
                // the oscillator rotation sits outside; zero and fs IF pass straight
                DCP_IF_VAR, DCP_IF_ZERO, DCP_IF_FS: begin
                    st_next.i = gi;
                    st_next.q = gq;
                    if (real_output_enable) begin
                        // quarter-rate rotation I, -Q, -I, Q keeps only the real part
                        case (st_reg.ph) // RULE4
                            2'b00: st_next.i = gi;
                            2'b01: st_next.i = dcp_sat_neg(gq);
                            2'b10: st_next.i = dcp_sat_neg(gi);
                            default: st_next.i = gq;
                        endcase
                        st_next.q = 16'h0000;
                        st_next.ph = st_reg.ph + 2'b01;
                    end
                end
                default: begin
                    st_next.i = gi;
                    st_next.q = gq;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.ctrl <= DCP_CTRL_RST;
            st_reg.insel <= DCP_INSEL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // keep one of every ratio samples; a bad code gives ratio zero and no output
    dcp_decimator u_decim (
        .clk(clk),
        .rst(rst),
        .ratio(st_reg.ratio),
        .real_out(real_output_enable),
        .in_vld(st_reg.vld),
        .in_i(st_reg.i),
        .in_q(st_reg.q),
        .out_i(out_i),
        .out_q(out_q),
        .out_i_vld(out_i_vld),
        .out_q_vld(out_q_vld)
    );

    assign cfg_rdata = st_reg.rdata;
    assign cfg_rvalid = st_reg.rvalid;
    assign stage_en = st_reg.stages;
    assign decim_ratio = st_reg.ratio;
    assign decim_code_bad = st_reg.bad;
    assign intermediate_freq_mode = st_reg.ctrl[DCP_IFM_LSB +: 2];

    // checks on the registered behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic plain_path;
    assign plain_path = (if_mode != DCP_IF_TEST) && !real_output_enable;

    property p_real_mix;
        smp_vld && plain_path && !mixer_type_bit && !cfg_wr |=> st_reg.q == st_reg.i;
    endproperty
    a_real_mix: assert property (p_real_mix) else $error("real mixing Q differs from I"); // RULE1

    property p_cplx_mix;
        smp_vld && plain_path && mixer_type_bit && !six_db_gain_bit && !cfg_wr
            |=> st_reg.q == $past(qsrc);
    endproperty
    a_cplx_mix: assert property (p_cplx_mix) else $error("complex Q source wrong"); // RULE1

    property p_unity;
        smp_vld && plain_path && !six_db_gain_bit && !cfg_wr |=> st_reg.i == $past(isrc);
    endproperty
    a_unity: assert property (p_unity) else $error("unity gain altered sample"); // RULE2

    property p_double;
        smp_vld && plain_path && six_db_gain_bit && !cfg_wr
            && (isrc[DCP_SW-1] == isrc[DCP_SW-2])
            |=> st_reg.i == {$past(isrc_x2)};
    endproperty
    a_double: assert property (p_double) else $error("6 dB gain not applied"); // RULE2

    property p_test;
        smp_vld && if_mode == DCP_IF_TEST && !cfg_wr |=> st_reg.q == ~st_reg.i;
    endproperty
    a_test: assert property (p_test) else $error("test pattern mismatch"); // RULE3

    // the ramp only moves on taken samples, so I must show the value held before the step
    property p_ramp;
        smp_vld && if_mode == DCP_IF_TEST && !cfg_wr |=> st_reg.i == $past(st_reg.ramp);
    endproperty
    a_ramp: assert property (p_ramp) else $error("test ramp out of step"); // RULE3

    property p_ifm_wr;
        cfg_wr && cfg_addr == DCP_ADDR_CTRL
            |=> intermediate_freq_mode == $past(cfg_wdata[DCP_IFM_LSB +: 2]);
    endproperty
    a_ifm_wr: assert property (p_ifm_wr) else $error("if mode not taken from write"); // RULE3

    property p_real_noq;
        real_output_enable [*3] |-> !out_q_vld;
    endproperty
    a_real_noq: assert property (p_real_noq) else $error("Q valid with real output"); // RULE4

    property p_hb12;
        decim_ratio_code == 3'b000 && !real_output_enable && !cfg_wr
            |=> decim_ratio == 6'd4 && stage_en == 6'h03;
    endproperty
    a_hb12: assert property (p_hb12) else $error("code 000 ratio wrong"); // RULE5 RULE9

    property p_hb1_real;
        decim_ratio_code == 3'b011 && real_output_enable && !cfg_wr |=> decim_ratio == 6'd1;
    endproperty
    a_hb1_real: assert property (p_hb1_real) else $error("code 011 real ratio wrong"); // RULE6

    property p_tb;
        decim_ratio_code == 3'b101 && real_output_enable && !cfg_wr
            |=> decim_ratio == 6'd6 && stage_en[DCP_STG_TB];
    endproperty
    a_tb: assert property (p_tb) else $error("code 101 ratio wrong"); // RULE7

    property p_ext48;
        decim_ratio_code == DCP_DEC_EXT && ext_ratio_code == DCP_EXT_TB_HB4
            && !real_output_enable && !cfg_wr |=> decim_ratio == 6'd48;
    endproperty
    a_ext48: assert property (p_ext48) else $error("extended code 0 ratio wrong"); // RULE8 RULE10

    property p_ext10;
        decim_ratio_code == DCP_DEC_EXT && ext_ratio_code == DCP_EXT_FB_HB1
            && !real_output_enable && !cfg_wr |=> decim_ratio == 6'd10 && stage_en == 6'h21;
    endproperty
    a_ext10: assert property (p_ext10) else $error("extended code 2 ratio wrong"); // RULE11

    property p_ext20;
        decim_ratio_code == DCP_DEC_EXT && ext_ratio_code == DCP_EXT_FB_HB3
            && real_output_enable && !cfg_wr |=> decim_ratio == 6'd20;
    endproperty
    a_ext20: assert property (p_ext20) else $error("extended code 4 real ratio wrong"); // RULE12

    property p_ext_fb2;
        decim_ratio_code == DCP_DEC_EXT && ext_ratio_code == DCP_EXT_FB_HB2
            && !real_output_enable && !cfg_wr |=> decim_ratio == 6'd20 && stage_en == 6'h23;
    endproperty
    a_ext_fb2: assert property (p_ext_fb2) else $error("extended code 3 ratio wrong"); // RULE12

    property p_resv;
        cfg_rd && cfg_addr == DCP_ADDR_INSEL |=> cfg_rvalid && !cfg_rdata[3] && !cfg_rdata[1];
    endproperty
    a_resv: assert property (p_resv) else $error("reserved input select bits set"); // RULE13

    property p_spacing;
        out_i_vld && decim_ratio == 6'd4 && $stable(decim_ratio) |=> !out_i_vld [*3];
    endproperty
    a_spacing: assert property (p_spacing) else $error("kept samples too close"); // RULE5
endmodule

// >>> verification/dcp_sample_src.sv
// converter core model: feeds random channel a and b samples into the path
`timescale 1ns/100ps
module dcp_sample_src import dcp_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [7:0] count,
    input wire logic slow,
    output logic smp_vld,
    output logic [DCP_SW-1:0] smp_a,
    output logic [DCP_SW-1:0] smp_b,
    output logic busy
);
    logic [7:0] left_reg;
    logic gap_reg;

    // one sample a cycle, or one every other cycle when slow
    always @(posedge clk) begin
        if (rst) begin
            left_reg <= 8'h00;
            gap_reg <= 1'b0;
            smp_vld <= 1'b0;
            smp_a <= 16'h0000;
            smp_b <= 16'h0000;
        end else if (go) begin
            left_reg <= count;
            gap_reg <= 1'b0;
            smp_vld <= 1'b0;
        end else if (left_reg != 8'h00 && !gap_reg) begin
            smp_vld <= 1'b1;
            smp_a <= 16'($urandom);
            smp_b <= 16'($urandom);
            left_reg <= left_reg - 8'h01;
            gap_reg <= slow;
        end else begin
            smp_vld <= 1'b0;
            gap_reg <= 1'b0;
            // idle lines carry no sample: invert so a stale value never looks current
            smp_a <= ~smp_a;
            smp_b <= ~smp_b;
        end
    end

    assign busy = (left_reg != 8'h00);
endmodule

// >>> verification/downconverter_path_config_bench.sv
// self-checking bench for the second downconverter path configuration block
`timescale 1ns/100ps
module downconverter_path_config_bench import dcp_pkg::*; ;
    typedef struct packed {logic [15:0] i; logic [15:0] q; logic qv;} dcp_exp_t;
    localparam logic [7:0] RUN_CTRL [8] = '{8'hc0, 8'h13, 8'hab, 8'h8c, 8'h87, 8'h87, 8'h87, 8'h30};
    localparam logic [7:0] RUN_INSEL [8] = '{8'h01, 8'h05, 8'h04, 8'h04, 8'h24, 8'h14, 8'h04, 8'h01};
    localparam logic [7:0] RUN_LEN [8] = '{8'd20, 8'd16, 8'd12, 8'd13, 8'd21, 8'd8, 8'd50, 8'd16};
    logic clk, rst, cfg_wr, cfg_rd, cfg_rvalid, smp_vld, out_i_vld, out_q_vld;
    logic decim_code_bad, go, slow, busy;
    logic [14:0] cfg_addr;
    logic [7:0] cfg_wdata, cfg_rdata, count, ctrl_m, insel_m;
    logic [15:0] smp_a, smp_b, out_i, out_q, ei, eq, ramp_m;
    logic [5:0] stage_en, decim_ratio, ratio_m;
    logic [1:0] intermediate_freq_mode, ph_m;
    logic [12:0] cfg_x;
    int miscompares, tests_run, idx, cyc;
    dcp_exp_t sq[$];
    logic [7:0] rq[$];
    dcp_exp_t e;

    dcp_path_config u_dut (.clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .smp_vld(smp_vld), .smp_a(smp_a), .smp_b(smp_b), .out_i(out_i), .out_q(out_q),
        .out_i_vld(out_i_vld), .out_q_vld(out_q_vld), .stage_en(stage_en),
        .decim_ratio(decim_ratio), .decim_code_bad(decim_code_bad),
        .intermediate_freq_mode(intermediate_freq_mode));
    dcp_sample_src u_src (.clk(clk), .rst(rst), .go(go), .count(count), .slow(slow),
        .smp_vld(smp_vld), .smp_a(smp_a), .smp_b(smp_b), .busy(busy));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // saturating doubling and negation, kept apart from the design's own helpers
    function automatic logic [15:0] sat2(input logic [15:0] x);
        if (x[15] != x[14]) return x[15] ? 16'h8000 : 16'h7fff;
        return {x[14:0], 1'b0};
    endfunction
    function automatic logic [15:0] neg(input logic [15:0] x);
        return (x == 16'h8000) ? 16'h7fff : 16'h0000 - x;
    endfunction
    // expected {bad, ratio, stages}; stage bits hb1..hb4, third-band, fifth-band
    function automatic logic [12:0] exp_cfg(input logic [7:0] c, input logic [7:0] s);
        logic [5:0] r;
        logic [5:0] st;
        r = 6'h00;
        st = 6'h00;
        case (c[2:0])
            3'h0: begin r = 6'd4; st = 6'h03; end
            3'h1: begin r = 6'd8; st = 6'h07; end
            3'h2: begin r = 6'd16; st = 6'h0f; end
            3'h3: begin r = 6'd2; st = 6'h01; end
            3'h4: begin r = 6'd6; st = 6'h11; end
            3'h5: begin r = 6'd12; st = 6'h13; end
            3'h6: begin r = 6'd24; st = 6'h17; end
            default: begin
                case (s[7:4])
                    4'h0: begin r = 6'd48; st = 6'h1f; end
                    4'h2: begin r = 6'd10; st = 6'h21; end
                    4'h3: begin r = 6'd20; st = 6'h23; end
                    4'h4: begin r = 6'd40; st = 6'h27; end
                    default: r = 6'h00;
                endcase
            end
        endcase
        if (c[3]) r = r >> 1;
        return {r == 6'h00, r, st};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // register write; the model follows and restarts its count when the ratio moves
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        if (a == DCP_ADDR_CTRL) ctrl_m = d;
        if (a == DCP_ADDR_INSEL) insel_m = d & DCP_INSEL_RW_MASK;
        cfg_x = exp_cfg(ctrl_m, insel_m);
        if (cfg_x[11:6] != ratio_m) idx = 0;
        ratio_m = cfg_x[11:6];
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] exp);
        @(posedge clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        rq.push_back(exp);
        @(posedge clk);
        cfg_rd <= 1'b0;
    endtask

    // one burst from the converter model, then let the pipeline drain
    task automatic stream(input logic [7:0] n, input logic s);
        @(posedge clk);
        count <= n;
        slow <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 600 && busy; k++) @(posedge clk);
        repeat (5) @(posedge clk);
    endtask

    // watches taken samples and all results; oldest note is compared first
    always @(posedge clk) begin
        if (rst) begin
            idx = 0;
            ph_m = 2'd0;
            ramp_m = 16'h0000;
        end else begin
            if (smp_vld) begin
                ei = insel_m[0] ? smp_b : smp_a;
                eq = ctrl_m[7] ? (insel_m[2] ? smp_b : smp_a) : ei;
                if (ctrl_m[6]) begin
                    ei = sat2(ei);
                    eq = sat2(eq);
                end
                // test mode overrides gain and real output; rotation steps only on real samples
                if (ctrl_m[5:4] == 2'b11) begin
                    ei = ramp_m;
                    eq = ~ramp_m;
                    ramp_m++;
                end else if (ctrl_m[3]) begin
                    case (ph_m)
                        2'd1: ei = neg(eq);
                        2'd2: ei = neg(ei);
                        2'd3: ei = eq;
                        default: ei = ei;
                    endcase
                    eq = 16'h0000;
                    ph_m++;
                end
                if (ratio_m != 6'h00 && (idx % ratio_m) == 0) sq.push_back({ei, eq, !ctrl_m[3]});
                idx++;
            end
            if (out_i_vld) begin
                chk({15'h0, sq.size() != 0}, 16'h0001, "sample note");
                e = (sq.size() > 0) ? sq.pop_front() : '0;
                chk(out_i, e.i, "out_i");
                chk({15'h0, out_q_vld}, {15'h0, e.qv}, "out_q_vld");
                chk(out_q, e.q, "out_q");
            end else if (out_q_vld) begin
                chk(16'h0001, 16'h0000, "q without i");
            end
            if (cfg_rvalid) chk({8'h00, cfg_rdata}, {8'h00, rq.pop_front()}, "read");
        end
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            $display("[ERR] %0t run did not complete", $time);
            stop_test();
        end
    end

    initial begin
        rst = 1'b1;
        {cfg_wr, cfg_rd, go, slow} = 4'h0;
        cfg_addr = 15'h0000;
        {cfg_wdata, count, ctrl_m, insel_m} = 32'h0;
        ratio_m = 6'd4;
        miscompares = 0;
        tests_run = 0;
        idx = 0;
        cyc = 0;
        void'($urandom(32'habcc));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // reset values, reserved bits, unmapped place, random write and read back
        rd(DCP_ADDR_CTRL, DCP_CTRL_RST);
        rd(DCP_ADDR_INSEL, DCP_INSEL_RST);
        wr(DCP_ADDR_INSEL, 8'hff);
        rd(DCP_ADDR_INSEL, 8'hf5);
        wr(15'h0352, 8'h5a);
        rd(15'h0352, 8'h00);
        cfg_wdata <= 8'($urandom);
        @(posedge clk);
        wr(DCP_ADDR_CTRL, cfg_wdata);
        rd(DCP_ADDR_CTRL, ctrl_m);
        repeat (3) @(posedge clk);
        $display("test registers done");
        // every basic code, extended code, output kind and if mode
        for (int c = 0; c < 16; c++) begin
            for (int x = 0; x < 16; x++) begin
                wr(DCP_ADDR_INSEL, {x[3:0], 4'h0});
                wr(DCP_ADDR_CTRL, {2'($urandom), x[1:0], c[3:0]});
                repeat (3) @(posedge clk);
                cfg_x = exp_cfg(ctrl_m, insel_m);
                chk({10'h0, decim_ratio}, {10'h0, cfg_x[11:6]}, "ratio");
                chk({15'h0, decim_code_bad}, {15'h0, cfg_x[12]}, "bad code");
                chk({10'h0, stage_en}, {10'h0, cfg_x[5:0]}, "stages");
                chk({14'h0, intermediate_freq_mode}, {14'h0, x[1:0]}, "if mode");
            end
        end
        $display("test decimation table done");
        // sample bursts, fast and slow, over mixer, gain, real output and ratios
        for (int r = 0; r < 8; r++) begin
            wr(DCP_ADDR_INSEL, RUN_INSEL[r]);
            wr(DCP_ADDR_CTRL, RUN_CTRL[r]);
            repeat (4) @(posedge clk);
            stream(RUN_LEN[r], r[0]);
            chk(16'(sq.size()), 16'h0000, "missing samples");
            $display("test stream %0d done", r);
        end
        stop_test();
    end
endmodule
